// *** src/ppc_device.sv ***
`timescale 1ns/1ps
`include "ppc_cfg.svh"
// What this block does
// - manual mode only entered from compatibility
// - manual direction bit selects bus direction
// - manual output enable floats or drives bus
// - override drives five outputs, else three
// - input value, edge masks, change status
// - signal change interrupt needs its enable
// - datapath direction: zero in, one out
// - pipeline lock halts fifo draining
// - only host starts negotiation; enables decide, except epp is always accepted
// - stay compatibility until negotiation succeeds
// - negotiation needs allow; transfers need enable
// - status bits success, failure, invalid
// - low nibble holds mode code
// - set busy asserts busy; clear restores
// - strobe raises busy, latch, ack, drop
// - status lines only while busy high
// - busy while strobe, ack inside busy
// - negotiation enable bit map, id request
// - reverse request drives data available during negotiation
// - ecp command tag as ninth bit
// - init low in ecp or rle terminates, never reverses; reverse request kept until written
// - epp address write stored, interrupts
// - reset starts in compatibility mode
module ppc_device (
  input wire logic sys_clk,
  input wire logic rst,
  ppc_link_if.device link,
  input wire logic [3:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  input wire logic fifo_ready,
  output logic fifo_valid,
  output logic [8:0] fifo_data,
  output logic port_irq
);
  // local register index map
  localparam logic [3:0] A_PCR = 4'h0, A_NSR = 4'h1, A_SCR = 4'h2, A_NER = 4'h3;
  localparam logic [3:0] A_IER = 4'h4, A_ISR = 4'h5, A_MDR = 4'h6, A_OVR = 4'h7;
  localparam logic [3:0] A_IVR = 4'h8, A_FEM = 4'h9, A_REM = 4'ha, A_SSR = 4'hb;
  localparam logic [3:0] A_PIPELINE_AUX_CONTROL = 4'hc, A_EAR = 4'hd, A_DIR = 4'he;
  localparam logic [4:0] ACK_CYC = 5'(`PPC_ACK_CYC);
  logic [7:0] port_control, negotiation_status, special_command, negotiation_enable;
  logic [7:0] port_irq_enable, port_irq_status, manual_data_reg, output_override_reg;
  logic [3:0] falling_edge_mask, rising_edge_mask, signal_change_status;
  logic [7:0] pipeline_aux_control, epp_address_reg;
  logic datapath_direction; // 0 in, 1 out
  logic busy_hold; // set busy active
  logic [3:0] mode; // current mode code
  logic ecp_reverse; // host turned ecp around
  // input synchronisers
  logic [3:0] in_s1, in_s2, in_prev;
  logic [7:0] pd_s1, pd_s2;
  ppc_pkg::ppc_hs_t hs;
  logic [4:0] ack_cnt;
  logic [7:0] latch;
  logic latch_cmd;
  logic negotiating;
  logic [3:0] neg_req;
  logic bus_wr;
  logic fifo_in_ready, fifo_in_valid;
  logic manual;
  assign manual = port_control[`PPC_PCR_MANUAL];
  // bit 0 strobe, 1 host busy, 2 select, 3 init
  always_ff @(posedge sys_clk)
  begin
    in_s1 <= {link.init_n, link.select_in, link.host_busy_in, link.host_strobe_in};
    in_s2 <= in_s1;
    in_prev <= in_s2;
    pd_s1 <= link.parallel_data_bus;
    pd_s2 <= pd_s1;
  end
  // software accepts a write this cycle
  assign bus_wr = reg_wr;
  // control registers written by software
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      port_control <= 8'h00;
      negotiation_enable <= 8'h00;
      port_irq_enable <= 8'h00;
      manual_data_reg <= 8'h00;
      output_override_reg <= 8'h00;
      falling_edge_mask <= 4'h0;
      rising_edge_mask <= 4'h0;
      pipeline_aux_control <= 8'h00;
      datapath_direction <= 1'b0;
    end
    else if (bus_wr)
    begin
      if (reg_addr == A_PCR)
      begin
        port_control <= reg_wdata;
        if (mode != `PPC_MODE_COMPAT)
          port_control[`PPC_PCR_MANUAL] <= port_control[`PPC_PCR_MANUAL];
      end
      else if (reg_addr == A_NER)
        negotiation_enable <= reg_wdata;
      else if (reg_addr == A_IER)
        port_irq_enable <= reg_wdata;
      else if (reg_addr == A_MDR)
        manual_data_reg <= reg_wdata;
      else if (reg_addr == A_OVR)
        output_override_reg <= reg_wdata;
      else if (reg_addr == A_FEM)
        falling_edge_mask <= reg_wdata[3:0];
      else if (reg_addr == A_REM)
        rising_edge_mask <= reg_wdata[3:0];
      else if (reg_addr == A_PIPELINE_AUX_CONTROL)
        pipeline_aux_control <= reg_wdata;
      else if (reg_addr == A_DIR)
        datapath_direction <= reg_wdata[0];
    end
  end
  // edge-masked change status, set beats clear
  always_ff @(posedge sys_clk)
  begin
    if (rst)
      signal_change_status <= 4'h0;
    else
      signal_change_status <= ((bus_wr && reg_addr == A_SSR) ?
        (signal_change_status & ~reg_wdata[3:0]) : signal_change_status) |
        (in_prev & ~in_s2 & falling_edge_mask) | (~in_prev & in_s2 & rising_edge_mask);
  end
  // negotiation: a rising edge on select starts a request when allow is set and manual is off
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      negotiating <= 1'b0;
      neg_req <= 4'h0;
      mode <= `PPC_MODE_COMPAT;
      negotiation_status <= 8'h00;
      ecp_reverse <= 1'b0;
    end
    else if (!negotiating && in_s2[2] && !in_prev[2] && port_control[`PPC_PCR_ALLOW] && !manual)
    begin
      negotiating <= 1'b1;
      neg_req <= pd_s2[3:0];
    end
    else if (negotiating && !in_s2[2])
    begin
      negotiating <= 1'b0;
      if (mode_ok(neg_req, negotiation_enable))
      begin
        mode <= neg_req;
        negotiation_status <= {2'b10, 2'b00, neg_req};
      end
      else
        negotiation_status <= {2'b01, 2'b00, mode};
    end
    // termination: init pulled low
    else if (mode != `PPC_MODE_COMPAT && !in_s2[3])
    begin
      negotiation_status <= {2'b10, 1'b0, (hs != ppc_pkg::ppc_idle), mode};
      mode <= `PPC_MODE_COMPAT;
      ecp_reverse <= 1'b0;
    end
    // ecp or rle with init high: ecp_reverse cleared; init low took the termination branch
    else if (mode == `PPC_MODE_ECP || mode == `PPC_MODE_RLE)
      ecp_reverse <= !in_s2[3];
  end
  // mode acceptance from enable bits
  function automatic logic mode_ok(input logic [3:0] m, input logic [7:0] en);
    mode_ok = (m == `PPC_MODE_NIBBLE && en[`PPC_NER_NIBBLE]) ||
      (m == `PPC_MODE_BYTE && en[`PPC_NER_BYTE]) ||
      (m == `PPC_MODE_ECP && en[`PPC_NER_ECP]) ||
      (m == `PPC_MODE_RLE && en[`PPC_NER_ECP] && en[`PPC_NER_RLE]) ||
      (m == `PPC_MODE_EPP);
  endfunction : mode_ok
  // busy while strobe, ack inside busy
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      hs <= ppc_pkg::ppc_idle;
      ack_cnt <= 5'h0;
      latch <= 8'h00;
      latch_cmd <= 1'b0;
    end
    else
    case (hs)
      ppc_pkg::ppc_idle:
        if (!in_s2[0] && in_prev[0] && port_control[`PPC_PCR_XFER] && !manual && !negotiating)
        begin
          latch <= pd_s2;
          latch_cmd <= !in_s2[1];
          hs <= ppc_pkg::ppc_latched;
        end
      ppc_pkg::ppc_latched:
        if (in_s2[0])
        begin
          ack_cnt <= ACK_CYC;
          hs <= ppc_pkg::ppc_ack;
        end
      ppc_pkg::ppc_ack:
        if (ack_cnt == 5'h1)
          hs <= ppc_pkg::ppc_wait_fifo;
        else
          ack_cnt <= ack_cnt - 5'h1;
      default:
        if (fifo_in_ready)
          hs <= ppc_pkg::ppc_idle;
    endcase
  end
  assign fifo_in_valid = (hs == ppc_pkg::ppc_wait_fifo);
  // set busy and clear busy; reverse request auto clear needs ecp_reverse, which never sets
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      special_command <= 8'h00;
      busy_hold <= 1'b0;
    end
    else
    begin
      special_command <= (bus_wr && reg_addr == A_SCR) ? (reg_wdata & 8'h01) :
        (special_command & 8'h01);
      if (bus_wr && reg_addr == A_SCR && reg_wdata[`PPC_SCR_CLRBUSY])
        busy_hold <= 1'b0;
      else if (bus_wr && reg_addr == A_SCR && reg_wdata[`PPC_SCR_SETBUSY])
        busy_hold <= 1'b1;
      if (ecp_reverse && !(bus_wr && reg_addr == A_SCR))
        special_command[`PPC_SCR_REVERSE_REQUEST] <= 1'b0;
    end
  end
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      port_irq_status <= 8'h00;
      epp_address_reg <= 8'h00;
    end
    else
    begin
      port_irq_status <= ((bus_wr && reg_addr == A_ISR) ? (port_irq_status & ~reg_wdata) :
        port_irq_status) |
        {3'b000, (|signal_change_status), 1'b0,
         (mode == `PPC_MODE_EPP && !in_s2[2] && in_prev[2]),
         (ecp_reverse && special_command[`PPC_SCR_REVERSE_REQUEST]),
         (negotiating && !in_s2[2])} |
        ((negotiating && !in_s2[2] && pd_s2[`PPC_NER_ID] && negotiation_enable[`PPC_NER_ID] &&
          neg_req != `PPC_MODE_EPP) ? 8'h08 : 8'h00);
      if (mode == `PPC_MODE_EPP && !in_s2[2] && in_prev[2] && in_s2[0] == 1'b0)
        epp_address_reg <= pd_s2;
    end
  end
  assign port_irq = |(port_irq_status & port_irq_enable);
  ppc_fifo #(.WIDTH(9), .DEPTH(`PPC_FIFO_DEPTH)) u_fifo (
    .sys_clk(sys_clk), .rst(rst),
    .in_valid(fifo_in_valid), .in_ready(fifo_in_ready), .in_data({latch_cmd, latch}),
    .out_valid(fifo_valid),
    .out_ready(fifo_ready && !pipeline_aux_control[`PPC_PIPELINE_AUX_CONTROL_LOCK]),
    .out_data(fifo_data));
  // register readback
  always_comb
  begin
    if (reg_addr == A_PCR) reg_rdata = port_control;
    else if (reg_addr == A_NSR) reg_rdata = negotiation_status;
    else if (reg_addr == A_SCR) reg_rdata = special_command;
    else if (reg_addr == A_NER) reg_rdata = negotiation_enable;
    else if (reg_addr == A_IER) reg_rdata = port_irq_enable;
    else if (reg_addr == A_ISR) reg_rdata = port_irq_status;
    else if (reg_addr == A_MDR) reg_rdata = port_control[`PPC_PCR_DIR] ? manual_data_reg : pd_s2;
    else if (reg_addr == A_OVR) reg_rdata = output_override_reg;
    else if (reg_addr == A_IVR) reg_rdata = {4'h0, in_s2};
    else if (reg_addr == A_FEM) reg_rdata = {4'h0, falling_edge_mask};
    else if (reg_addr == A_REM) reg_rdata = {4'h0, rising_edge_mask};
    else if (reg_addr == A_SSR) reg_rdata = {4'h0, signal_change_status};
    else if (reg_addr == A_PIPELINE_AUX_CONTROL) reg_rdata = pipeline_aux_control;
    else if (reg_addr == A_EAR) reg_rdata = epp_address_reg;
    else if (reg_addr == A_DIR) reg_rdata = {7'h00, datapath_direction};
    else reg_rdata = 8'h00;
  end
  // link outputs: override bits 0 busy,1 ack,2 perror,3 fault,4 select
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      link.data_dev <= 8'h00;
      link.data_dev_oe_n <= 1'b1;
      link.peripheral_busy_out <= 1'b0;
      link.peripheral_ack_out <= 1'b1;
      link.data_available_n <= 1'b1;
      link.paper_error <= 1'b0;
      link.select_out <= 1'b0;
    end
    else if (manual)
    begin
      link.data_dev <= manual_data_reg;
      link.data_dev_oe_n <= !(port_control[`PPC_PCR_DIR] && port_control[`PPC_PCR_OE]);
      link.peripheral_busy_out <= output_override_reg[0];
      link.peripheral_ack_out <= output_override_reg[1];
      link.paper_error <= output_override_reg[2];
      link.data_available_n <= output_override_reg[3];
      link.select_out <= output_override_reg[4];
    end
    else
    begin
      link.data_dev <= epp_address_reg;
      link.data_dev_oe_n <= !(mode == `PPC_MODE_EPP && !in_s2[2] && in_s2[0]);
      // busy from handshake, negotiation or set busy
      link.peripheral_busy_out <= busy_hold || (hs != ppc_pkg::ppc_idle) || !in_s2[0] || negotiating;
      link.peripheral_ack_out <= !(hs == ppc_pkg::ppc_ack);
      // status only under busy; three override
      link.paper_error <= busy_hold && output_override_reg[2];
      link.select_out <= busy_hold && output_override_reg[4];
      link.data_available_n <= negotiating ? !special_command[`PPC_SCR_REVERSE_REQUEST] :
        !(busy_hold && output_override_reg[3]);
    end
  end
endmodule : ppc_device

// *** src/ppc_cfg.svh ***
`ifndef PPC_CFG_SVH
`define PPC_CFG_SVH
// port_control fields
`define PPC_PCR_MANUAL 7
`define PPC_PCR_ALLOW 6
`define PPC_PCR_XFER 5
`define PPC_PCR_OE 2
`define PPC_PCR_DIR 1
// negotiation_status fields
`define PPC_NSR_OK 7
`define PPC_NSR_FAIL 6
`define PPC_NSR_INVALID 4
// special_command fields
`define PPC_SCR_REVERSE_REQUEST 0
`define PPC_SCR_EPPIRQ 1
`define PPC_SCR_SETBUSY 2
`define PPC_SCR_CLRBUSY 3
// negotiation_enable fields
`define PPC_NER_NIBBLE 0
`define PPC_NER_BYTE 1
`define PPC_NER_ECP 2
`define PPC_NER_RLE 3
`define PPC_NER_ID 6
// irq status / enable fields
`define PPC_IRQ_NEG 0
`define PPC_IRQ_DIRECTION_CHANGE_STATUS 1
`define PPC_IRQ_EPP_ADDRESS_WRITE_IRQ 2
`define PPC_IRQ_ID_REQUEST_FLAG 3
`define PPC_IRQ_SIGNAL_CHANGE_ENABLE 4
// pipeline_aux_control field
`define PPC_PIPELINE_AUX_CONTROL_LOCK 4
// mode codes in negotiation_status
`define PPC_MODE_COMPAT 4'h0
`define PPC_MODE_NIBBLE 4'h1
`define PPC_MODE_BYTE 4'h2
`define PPC_MODE_ECP 4'h3
`define PPC_MODE_RLE 4'h4
`define PPC_MODE_EPP 4'h5
// ack pulse length: 500 ns at 20 MHz
`define PPC_ACK_NS 500
`define PPC_CLK_NS 50
`define PPC_ACK_CYC ((`PPC_ACK_NS + `PPC_CLK_NS - 1) / `PPC_CLK_NS)
`define PPC_FIFO_DEPTH 8
`endif

// *** src/ppc_pkg.sv ***
package ppc_pkg;
  // device-side handshake state
  typedef enum logic [1:0] {ppc_idle, ppc_latched, ppc_ack, ppc_wait_fifo} ppc_hs_t;
  // host-side state
  typedef enum logic [1:0] {ppc_h_idle, ppc_h_strobe, ppc_h_wait} ppc_host_t;
endpackage : ppc_pkg

// *** src/ppc_link_if.sv ***
`timescale 1ns/1ps
// link between host port and peripheral port
interface ppc_link_if;
  logic [7:0] data_host; // host drive value
  logic data_host_oe_n; // host drives when low
  logic [7:0] data_dev; // device drive value
  logic data_dev_oe_n; // device drives when low
  logic host_strobe_in; // strobe, active low on wire
  logic host_busy_in; // autofeed / host busy
  logic select_in; // 1284 select request
  logic init_n; // init, active low
  logic peripheral_busy_out; // busy
  logic peripheral_ack_out; // ack, active low
  logic data_available_n; // fault / data available
  logic paper_error; // perror
  logic select_out; // select
  // resolved bus level
  logic [7:0] parallel_data_bus;
  assign parallel_data_bus = !data_host_oe_n ? data_host :
    (!data_dev_oe_n ? data_dev : 8'hff);
  modport device (input parallel_data_bus, host_strobe_in, host_busy_in, select_in, init_n,
    output data_dev, data_dev_oe_n, peripheral_busy_out, peripheral_ack_out,
    data_available_n, paper_error, select_out);
  modport host (input parallel_data_bus, peripheral_busy_out, peripheral_ack_out,
    data_available_n, paper_error, select_out,
    output data_host, data_host_oe_n, host_strobe_in, host_busy_in, select_in, init_n);
endinterface : ppc_link_if

// *** src/ppc_fifo.sv ***
`timescale 1ns/1ps
// small synchronous fifo with valid/ready both sides
module ppc_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 8
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  // storage
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0] count;
  logic push;
  logic pop;
  assign in_ready = (count != (AW+1)'(DEPTH));
  assign out_valid = (count != '0);
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign out_data = mem[rd_ptr];
  // write side
  always_ff @(posedge sys_clk)
  begin
    if (push)
    begin
      mem[wr_ptr] <= in_data;
    end
  end
  // pointers and fill count
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end
    else
    begin
      if (push)
        wr_ptr <= (wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1;
      if (pop)
        rd_ptr <= (rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1;
      count <= count + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule : ppc_fifo

// *** src/ppc_host.sv ***
`timescale 1ns/1ps
`include "ppc_cfg.svh"
// host end: sends compatibility bytes and requests negotiation
module ppc_host (
  input wire logic sys_clk,
  input wire logic rst,
  ppc_link_if.host link,
  input wire logic send_valid,
  output logic send_ready,
  input wire logic [7:0] send_data,
  input wire logic neg_start,
  input wire logic neg_end,
  input wire logic [7:0] neg_ext,
  output logic [7:0] status
);
  localparam logic [4:0] STB_CYC = 5'(`PPC_ACK_CYC);
  ppc_pkg::ppc_host_t st;
  logic [4:0] cnt;
  logic [4:0] bsy_s1, bsy_s2;
  assign send_ready = (st == ppc_pkg::ppc_h_idle) && !bsy_s2[0];
  // sync device status pins
  always_ff @(posedge sys_clk)
  begin
    bsy_s1 <= {link.select_out, link.data_available_n, link.paper_error,
      link.peripheral_ack_out, link.peripheral_busy_out};
    bsy_s2 <= bsy_s1;
    status <= {3'b000, bsy_s2};
  end
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      st <= ppc_pkg::ppc_h_idle;
      cnt <= 5'h0;
      link.data_host <= 8'h00;
      link.data_host_oe_n <= 1'b0;
      link.host_strobe_in <= 1'b1;
      link.host_busy_in <= 1'b1;
      link.select_in <= 1'b0;
      link.init_n <= 1'b1;
    end
    else
    begin
      // end request with select already low pulses init to terminate the mode
      link.init_n <= !(neg_end && !link.select_in);
      if (neg_start)
      begin
        link.data_host <= neg_ext;
        link.select_in <= 1'b1;
      end
      else if (neg_end)
        link.select_in <= 1'b0;
      case (st)
        ppc_pkg::ppc_h_idle:
          if (send_valid && !bsy_s2[0])
          begin
            link.data_host <= send_data;
            link.host_strobe_in <= 1'b0;
            cnt <= STB_CYC;
            st <= ppc_pkg::ppc_h_strobe;
          end
        ppc_pkg::ppc_h_strobe:
          if (cnt == 5'h1)
          begin
            link.host_strobe_in <= 1'b1;
            st <= ppc_pkg::ppc_h_wait;
          end
          else
            cnt <= cnt - 5'h1;
        default:
          if (bsy_s2[0] == 1'b0 && cnt == 5'h1)
            st <= ppc_pkg::ppc_h_idle;
      endcase
    end
  end
endmodule : ppc_host

// *** tb/ppc_link_monitor.sv ***
`timescale 1ns/1ps
// watches the compatibility handshake on the link between both ends
module ppc_link_monitor (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [7:0] data_host,
  input wire logic host_strobe_in,
  input wire logic select_in,
  input wire logic peripheral_busy_out,
  input wire logic peripheral_ack_out,
  input wire logic paper_error
);
  default clocking mon_cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  // ack pulse only inside busy
  ack_in_busy_a: assert property (!peripheral_ack_out |-> peripheral_busy_out)
    else $error("ack low while busy is low");
  // strobe raises busy within the sync delay
  busy_on_strobe_a: assert property ($fell(host_strobe_in) && !peripheral_busy_out && !select_in
    |-> ##[1:5] peripheral_busy_out)
    else $error("busy missing after strobe");
  // ack held low for exactly ten cycles
  ack_width_a: assert property ($fell(peripheral_ack_out) && peripheral_busy_out && !select_in
    |-> !peripheral_ack_out [*8] ##1 !peripheral_ack_out [*2] ##1 peripheral_ack_out)
    else $error("ack pulse width wrong");
  // ack starts only after strobe ended
  ack_after_strobe_a: assert property ($fell(peripheral_ack_out) && !select_in
    |-> host_strobe_in && peripheral_busy_out)
    else $error("ack began during strobe");
  // strobe end leads to ack soon
  ack_bound_a: assert property ($rose(host_strobe_in) && peripheral_busy_out && !select_in
    |-> ##[1:6] !peripheral_ack_out)
    else $error("ack late after strobe");
  // busy drops only with ack and strobe idle
  busy_drop_a: assert property ($fell(peripheral_busy_out)
    |-> peripheral_ack_out && host_strobe_in)
    else $error("busy dropped during handshake");
  // status line shown only while busy
  status_in_busy_a: assert property (!select_in && paper_error |-> peripheral_busy_out)
    else $error("paper error outside busy");
  // host holds data through the strobe
  host_data_hold_a: assert property (!host_strobe_in && !$past(host_strobe_in)
    |-> $stable(data_host))
    else $error("host data changed in strobe");
  // main scenarios reached
  cover property ($fell(peripheral_ack_out));
  cover property ($rose(select_in));
  cover property ($rose(peripheral_busy_out) && host_strobe_in);
endmodule : ppc_link_monitor

// *** tb/test_ieee1284_peripheral_port_control.sv ***
`timescale 1ns/1ps
`include "ppc_cfg.svh"
// host and device face each other; bench drives both user sides
module test_ieee1284_peripheral_port_control;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic [3:0] reg_addr = 4'h0;
  logic reg_wr = 1'b0;
  logic [7:0] reg_wdata = 8'h00;
  logic [7:0] reg_rdata;
  logic fifo_ready = 1'b0;
  logic fifo_valid;
  logic [8:0] fifo_data;
  logic port_irq;
  logic send_valid = 1'b0;
  logic send_ready;
  logic [7:0] send_data = 8'h00;
  logic neg_start = 1'b0;
  logic neg_end = 1'b0;
  logic [7:0] neg_ext = 8'h00;
  logic [7:0] status;
  logic [31:0] seed = 32'h3959a566;
  logic [7:0] rv;
  logic [7:0] tx_q[$]; // bytes waiting at the host
  logic [7:0] exp_q[$]; // model: bytes due out of the fifo
  logic [3:0] codes[4] = '{`PPC_MODE_NIBBLE, `PPC_MODE_BYTE, `PPC_MODE_ECP, `PPC_MODE_RLE};
  logic [7:0] ens[4] = '{8'h01, 8'h02, 8'h04, 8'h0c};
  int fifo_mode = 0; // 0 stall, 1 ready, 2 random
  logic locked = 1'b0; // model of the pipeline lock bit
  int miscompares = 0;
  int checks_done = 0;
  // 20 MHz clock
  always #25 sys_clk = ~sys_clk;
  ppc_link_if ppc_link_if_i ();
  ppc_device ppc_device_i (.sys_clk(sys_clk), .rst(rst), .link(ppc_link_if_i),
    .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .fifo_ready(fifo_ready), .fifo_valid(fifo_valid), .fifo_data(fifo_data),
    .port_irq(port_irq));
  ppc_host ppc_host_i (.sys_clk(sys_clk), .rst(rst), .link(ppc_link_if_i),
    .send_valid(send_valid), .send_ready(send_ready), .send_data(send_data),
    .neg_start(neg_start), .neg_end(neg_end), .neg_ext(neg_ext), .status(status));
  ppc_link_monitor ppc_link_monitor_i (.sys_clk(sys_clk), .rst(rst),
    .data_host(ppc_link_if_i.data_host), .host_strobe_in(ppc_link_if_i.host_strobe_in),
    .select_in(ppc_link_if_i.select_in), .peripheral_busy_out(ppc_link_if_i.peripheral_busy_out),
    .peripheral_ack_out(ppc_link_if_i.peripheral_ack_out),
    .paper_error(ppc_link_if_i.paper_error));
  // xorshift source of random values
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd
  // present queue head to the host, set fifo back-pressure
  always @(negedge sys_clk)
  begin
    send_valid <= tx_q.size() > 0;
    if (tx_q.size() > 0)
      send_data <= tx_q[0];
    fifo_ready <= (fifo_mode == 1) || (fifo_mode == 2 && rnd() % 2 == 1);
  end
  // drop a byte once the host has taken it
  always @(posedge sys_clk)
    if (send_valid && send_ready)
      tx_q.delete(0);
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp, input string what);
    checks_done++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("Error at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask : chk
  // each byte leaving the fifo matches the model in order
  always @(posedge sys_clk)
    if (!rst && fifo_valid && fifo_ready && !locked)
    begin
      chk(fifo_data[7:0], exp_q.pop_front(), "fifo byte");
      chk({7'h0, fifo_data[8]}, 8'h00, "command tag");
    end
  task automatic idle(input int n);
    repeat (n) @(negedge sys_clk);
  endtask : idle
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(negedge sys_clk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge sys_clk);
    reg_wr = 1'b0;
  endtask : wr
  task automatic rchk(input logic [3:0] a, input logic [7:0] exp, input string what);
    @(negedge sys_clk);
    reg_addr = a;
    @(posedge sys_clk);
    chk(reg_rdata, exp, what);
  endtask : rchk
  // host asks for a mode: select rises with the code, then falls to finish
  task automatic negotiate(input logic [3:0] code);
    @(negedge sys_clk);
    neg_ext = {4'h0, code};
    neg_start = 1'b1;
    @(negedge sys_clk);
    neg_start = 1'b0;
    idle(20);
    terminate();
  endtask : negotiate
  // end request: drops select, or with select already low pulses init
  task automatic terminate();
    @(negedge sys_clk);
    neg_end = 1'b1;
    @(negedge sys_clk);
    neg_end = 1'b0;
    idle(20);
  endtask : terminate
  task automatic push(input int n);
    for (int i = 0; i < n; i++)
    begin
      rv = rnd();
      tx_q.push_back(rv);
      exp_q.push_back(rv);
    end
  endtask : push
  task automatic test_done();
    $display("checks %0d miscompares %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : test_done
  // watchdog against a hung handshake
  initial
  begin
    repeat (20000) @(posedge sys_clk);
    miscompares++;
    test_done();
  end
  initial
  begin
    idle(8);
    rst = 1'b0;
    idle(4);
    rchk(4'h1, {4'h0, `PPC_MODE_COMPAT}, "status at reset");
    rchk(4'hf, 8'h00, "unmapped read");
    wr(4'h1, 8'hff);
    rchk(4'h1, 8'h00, "status read only");
    $display("test reset done");
    // fill the fifo until the port refuses, then drain with stalls
    wr(4'h0, 8'h60);
    push(9);
    idle(600);
    chk({7'h0, ppc_link_if_i.peripheral_busy_out}, 8'h01, "busy when full");
    fifo_mode = 2;
    idle(800);
    chk(8'(exp_q.size()), 8'h00, "fifo drained");
    chk({7'h0, fifo_valid}, 8'h00, "fifo empty");
    $display("test fifo done");
    // lock holds data in the fifo
    wr(4'hc, 8'h10);
    locked = 1'b1;
    fifo_mode = 1;
    push(3);
    idle(300);
    chk(8'(exp_q.size()), 8'h03, "lock holds");
    wr(4'hc, 8'h00);
    locked = 1'b0;
    idle(50);
    chk(8'(exp_q.size()), 8'h00, "unlock drains");
    $display("test lock done");
    // busy posted by command with a status line
    wr(4'h2, 8'h04);
    idle(2);
    chk({7'h0, ppc_link_if_i.peripheral_busy_out}, 8'h01, "set busy");
    wr(4'h7, 8'h04);
    idle(2);
    chk({7'h0, ppc_link_if_i.paper_error}, 8'h01, "status shown");
    rchk(4'h2, 8'h00, "command self clears");
    idle(2);
    chk(status, 8'h0f, "host sees status");
    wr(4'h7, 8'h00);
    wr(4'h2, 8'h08);
    idle(4);
    chk({7'h0, ppc_link_if_i.peripheral_busy_out}, 8'h00, "clear busy");
    push(1);
    idle(100);
    chk(8'(exp_q.size()), 8'h00, "running again");
    $display("test busy done");
    // nibble, byte, ecp and rle each accepted when enabled and refused when not
    wr(4'ha, 8'h0f);
    for (int i = 0; i < 4; i++)
    begin
      wr(4'h3, ens[i]);
      negotiate(codes[i]);
      rchk(4'h1, {4'h8, codes[i]}, "accepted");
      if (i == 0)
      begin
        wr(4'h0, 8'he0);
        rchk(4'h0, 8'h60, "manual refused");
      end
      terminate();
      wr(4'h3, 8'h00);
      negotiate(codes[i]);
      rchk(4'h1, {4'h4, `PPC_MODE_COMPAT}, "refused");
      terminate();
    end
    wr(4'h0, 8'h20);
    wr(4'h3, 8'h01);
    negotiate(`PPC_MODE_NIBBLE);
    rchk(4'h1, {4'h4, `PPC_MODE_COMPAT}, "allow bit clear");
    terminate();
    $display("test negotiation done");
    // interrupt follows status and its enable
    chk({7'h0, port_irq}, 8'h00, "irq disabled");
    wr(4'h4, 8'h10);
    idle(1);
    chk({7'h0, port_irq}, 8'h01, "signal change irq");
    wr(4'hb, 8'hff);
    wr(4'h5, 8'hff);
    idle(1);
    chk({7'h0, port_irq}, 8'h00, "irq cleared");
    $display("test interrupt done");
    test_done();
  end
endmodule : test_ieee1284_peripheral_port_control
